/* File: common/ipt_pkg.sv */
// Overview of operation
// - Data bytes travel least significant byte first in both directions.
// - Write data byte count must match length; 16/32-bit values stored at address.
// - 64-bit write stores low four bytes at address, high four at address plus 2.
// - Read returns length-field bytes; 64-bit reads fetch address then address plus 2.
// - Read address is refused while data is not ready; controller retries bare read phase.
// - With checksum on, device appends CRC over write byte, control, read byte, data.
// - Two receive buffers alternate; a request arriving during parsing is captured whole.
// - With both receive buffers pending, a new write address byte is refused.
// - Read results go to two transmit buffers; reads wait while both are occupied.
// - Transmit buffer freed after full readout; a cut-short read restarts from byte zero.
// - CRC-8 polynomial x^8+x^2+x+1, register preset to all ones.
// - Write packets with a mismatching received CRC are silently dropped.
// - Bus byte capture is never held up by packet processing.
// - Control word: direction, checksum enable, length, section, page, offset fields.
// - Length code 00 is 16-bit, 01 is 32-bit, 10 is 64-bit, 11 reserved.
// - Bus target address resets to 0x01 and is software configurable.
package ipt_pkg;
  localparam logic [6:0]  ADDR_RST   = 7'h01;
  localparam logic [7:0]  CRC_INIT   = 8'hff;
  localparam logic [7:0]  CRC_POLY   = 8'h07;
  localparam int          CW_DIR     = 23;
  localparam int          CW_CRC     = 22;
  localparam int          CW_LEN_HI  = 21;
  localparam int          CW_LEN_LO  = 20;
  localparam int          CW_ADDR_HI = 19;
  localparam logic [1:0]  LEN16      = 2'h0;
  localparam logic [1:0]  LEN32      = 2'h1;
  localparam logic [1:0]  LEN64      = 2'h2;
  localparam logic [1:0]  LENRSV     = 2'h3;
  localparam logic [3:0]  CW_BYTES   = 4'h3;
  localparam logic [3:0]  CNT_MAX    = 4'hf;
  localparam logic [3:0]  DATA_END   = 4'hb;
  localparam logic [3:0]  CRC_PRE    = 4'h5;
  localparam logic [3:0]  K_RADDR    = 4'h4;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [21:0] ADDR_STEP  = 22'h000002;
  localparam logic [7:0]  REG_CFG    = 8'h00;
  localparam logic [7:0]  REG_STAT   = 8'h04;

  typedef struct packed {
    logic [23:0] ctrl;
    logic [63:0] data;
    logic [3:0]  cnt;
    logic        crc_ok;
  } ipt_rx_type;

  typedef struct packed {
    logic [63:0] data;
    logic [7:0]  crc;
    logic [3:0]  n;
    logic        crc_en;
  } ipt_tx_type;

  typedef struct packed {
    logic [15:0] rsvd_hi;
    logic [7:0]  drops;
    logic [2:0]  rsvd_lo;
    logic        busy;
    logic [1:0]  tx_full;
    logic [1:0]  rx_full;
  } ipt_stat_type;

  // One byte through the CRC, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = (r[7] ^ b[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
    end
    return r;
  endfunction : crc8
endpackage : ipt_pkg

/* File: design/ipt_engine.sv */
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/100ps
module ipt_engine #(
  parameter int PADDR_W = 8
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               scl_i,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe_b,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  output logic                    mem_req,
  output logic                    mem_we,
  output logic                    mem_wide,
  output logic [21:0]             mem_addr,
  output logic [31:0]             mem_wdata,
  input  wire logic               mem_ack,
  input  wire logic [31:0]        mem_rdata
);
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_RX, L_ACKON, L_ACK, L_TX, L_TACK, L_TXLD}
    ipt_link_type;
  typedef enum logic [1:0] {P_IDLE, P_MEM, P_CRC} ipt_proc_type;

  function automatic logic [3:0] len_bytes(input logic [1:0] len);
    unique case (len)
      ipt_pkg::LEN16: return 4'h2;
      ipt_pkg::LEN32: return 4'h4;
      ipt_pkg::LEN64: return 4'h8;
      default:        return 4'h0;
    endcase
  endfunction : len_bytes

  logic               scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  ipt_link_type       l_state_q;
  logic [2:0]         bit_q;
  logic [7:0]         sr_q, tx_sr_q, cap_crc_q, drops_q;
  logic               ack_q, tx_mode_q, cap_act_q;
  logic [6:0]         tgt_q;
  logic [3:0]         tx_idx_q;
  ipt_pkg::ipt_rx_type cap_q;
  ipt_pkg::ipt_rx_type rx_buf_q [2];
  ipt_pkg::ipt_tx_type tx_buf_q [2];
  logic [1:0]         rx_full_q, tx_full_q;
  logic               wr_sel_q, pr_sel_q, tf_sel_q, rd_sel_q;
  ipt_proc_type       p_state_q;
  logic               part_q;
  logic [63:0]        rd_data_q;
  logic [7:0]         crc_q;
  logic [3:0]         k_q;
  ipt_pkg::ipt_stat_type stat;

  // Pin synchronisers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_i;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_i;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
    end
  end

  wire scl_rise  = scl_s2_q & ~scl_s3_q;
  wire scl_fall  = ~scl_s2_q & scl_s3_q;
  wire start_det = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q;
  wire stop_det  = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q;
  wire frame_end = start_det | stop_det;
  wire [7:0] sr_next = {sr_q[6:0], sda_s2_q};
  wire byte_done = scl_rise && (bit_q == ipt_pkg::BIT_LAST)
                   && (l_state_q == L_ADDR || l_state_q == L_RX);
  wire addr_hit  = byte_done && (l_state_q == L_ADDR) && (sr_next[7:1] == tgt_q);
  wire rx_set    = frame_end && cap_act_q && (cap_q.cnt >= ipt_pkg::CW_BYTES);

  ipt_pkg::ipt_tx_type tx_cur;
  logic [7:0]          tx_now;
  logic [3:0]          tx_total;
  always_comb begin
    tx_cur   = tx_buf_q[rd_sel_q];
    tx_total = tx_cur.n + {3'h0, tx_cur.crc_en};
    tx_now   = (tx_idx_q < tx_cur.n) ? tx_cur.data[{tx_idx_q[2:0], 3'h0} +: 8] : tx_cur.crc;
  end
  wire tx_clr = (l_state_q == L_TACK) && scl_rise && (tx_idx_q + 4'h1 == tx_total);

  // Byte-level bus target
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      l_state_q <= L_IDLE;
      bit_q     <= '0;
      sr_q      <= '0;
      tx_sr_q   <= '0;
      ack_q     <= 1'b0;
      tx_mode_q <= 1'b0;
      tx_idx_q  <= '0;
      sda_oe_b  <= 1'b1;
      sda_o     <= 1'b0;
    end else if (start_det) begin
      l_state_q <= L_ADDR;
      bit_q     <= '0;
      sda_oe_b  <= 1'b1;
    end else if (stop_det) begin
      l_state_q <= L_IDLE;
      sda_oe_b  <= 1'b1;
    end else begin
      unique case (l_state_q)
        L_IDLE: ;
        L_ADDR, L_RX: begin
          if (scl_rise) begin
            sr_q  <= sr_next;
            bit_q <= bit_q + 3'h1;
          end
          if (byte_done) begin
            l_state_q <= L_ACKON;
            if (l_state_q == L_RX) begin
              ack_q <= 1'b1;
            end else begin
              tx_mode_q <= sr_next[0];
              tx_idx_q  <= '0;
              ack_q     <= addr_hit && (sr_next[0] ? tx_full_q[rd_sel_q]
                                                   : !rx_full_q[wr_sel_q]);
            end
          end
        end
        L_ACKON: if (scl_fall) begin
          sda_oe_b  <= ~ack_q;
          l_state_q <= L_ACK;
        end
        L_ACK: if (scl_fall) begin
          bit_q <= '0;
          if (!ack_q) begin
            sda_oe_b  <= 1'b1;
            l_state_q <= L_IDLE;
          end else if (tx_mode_q) begin
            tx_sr_q   <= tx_now;
            sda_oe_b  <= tx_now[7];
            l_state_q <= L_TX;
          end else begin
            sda_oe_b  <= 1'b1;
            l_state_q <= L_RX;
          end
        end
        L_TX: if (scl_fall) begin
          if (bit_q == ipt_pkg::BIT_LAST) begin
            sda_oe_b  <= 1'b1;
            l_state_q <= L_TACK;
          end else begin
            bit_q    <= bit_q + 3'h1;
            tx_sr_q  <= {tx_sr_q[6:0], 1'b0};
            sda_oe_b <= tx_sr_q[6];
          end
        end
        L_TACK: if (scl_rise) begin
          tx_idx_q  <= tx_idx_q + 4'h1;
          l_state_q <= sda_s2_q ? L_IDLE : L_TXLD;
        end
        L_TXLD: if (scl_fall) begin
          tx_sr_q   <= tx_now;
          sda_oe_b  <= tx_now[7];
          bit_q     <= '0;
          l_state_q <= L_TX;
        end
      endcase
    end
  end

  // Packet capture into the free receive buffer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cap_act_q <= 1'b0;
      cap_q     <= '0;
      cap_crc_q <= ipt_pkg::CRC_INIT;
    end else if (frame_end) begin
      cap_act_q <= 1'b0;
      if (rx_set) begin
        rx_buf_q[wr_sel_q]        <= cap_q;
        rx_buf_q[wr_sel_q].crc_ok <= (cap_crc_q == 8'h00);
      end
    end else if (addr_hit && !sr_next[0] && !rx_full_q[wr_sel_q]) begin
      cap_act_q <= 1'b1;
      cap_q     <= '0;
      cap_crc_q <= ipt_pkg::crc8(ipt_pkg::CRC_INIT, sr_next);
    end else if (cap_act_q && byte_done && l_state_q == L_RX) begin
      cap_crc_q <= ipt_pkg::crc8(cap_crc_q, sr_next);
      if (cap_q.cnt < ipt_pkg::CW_BYTES) begin
        cap_q.ctrl <= {cap_q.ctrl[15:0], sr_next};
      end else if (cap_q.cnt < ipt_pkg::DATA_END) begin
        cap_q.data[{3'(cap_q.cnt - ipt_pkg::CW_BYTES), 3'h0} +: 8] <= sr_next;
      end
      if (cap_q.cnt != ipt_pkg::CNT_MAX) begin
        cap_q.cnt <= cap_q.cnt + 4'h1;
      end
    end
  end

  ipt_pkg::ipt_rx_type pe;
  logic [1:0] pe_len;
  logic [3:0] pe_n;
  logic       pe_rd, pe_crc, pe_bad, crc_bad;
  logic [7:0] crc_byte;
  always_comb begin
    pe      = rx_buf_q[pr_sel_q];
    pe_len  = pe.ctrl[ipt_pkg::CW_LEN_HI:ipt_pkg::CW_LEN_LO];
    pe_n    = len_bytes(pe_len);
    pe_rd   = pe.ctrl[ipt_pkg::CW_DIR];
    pe_crc  = pe.ctrl[ipt_pkg::CW_CRC];
    crc_bad = !pe_rd && pe_crc && !pe.crc_ok;
    pe_bad  = (pe_len == ipt_pkg::LENRSV) || crc_bad
              || (!pe_rd && pe.cnt != ipt_pkg::CW_BYTES + pe_n + {3'h0, pe_crc});
    if (k_q == 4'h0) begin
      crc_byte = {tgt_q, 1'b0};
    end else if (k_q < ipt_pkg::K_RADDR) begin
      crc_byte = pe.ctrl[{2'(ipt_pkg::CW_BYTES - k_q), 3'h0} +: 8];
    end else if (k_q == ipt_pkg::K_RADDR) begin
      crc_byte = {tgt_q, 1'b1};
    end else begin
      crc_byte = rd_data_q[{3'(k_q - ipt_pkg::CRC_PRE), 3'h0} +: 8];
    end
  end

  wire p_go     = (p_state_q == P_IDLE) && rx_full_q[pr_sel_q];
  wire mem_fin  = (p_state_q == P_MEM) && mem_ack && (part_q || pe_len != ipt_pkg::LEN64);
  wire tx_set   = (p_state_q == P_CRC) && (k_q == ipt_pkg::CRC_PRE + pe_n - 4'h1);
  wire rx_clr   = (p_go && pe_bad) || (mem_fin && mem_we) || tx_set;

  // Request parser and memory sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      p_state_q <= P_IDLE;
      mem_req   <= 1'b0;
      mem_we    <= 1'b0;
      mem_wide  <= 1'b0;
      mem_addr  <= '0;
      mem_wdata <= '0;
      part_q    <= 1'b0;
      rd_data_q <= '0;
      crc_q     <= ipt_pkg::CRC_INIT;
      k_q       <= '0;
    end else begin
      unique case (p_state_q)
        P_IDLE: if (p_go && !pe_bad && (!pe_rd || !tx_full_q[tf_sel_q])) begin
          mem_req   <= 1'b1;
          mem_we    <= !pe_rd;
          mem_wide  <= (pe_len != ipt_pkg::LEN16);
          mem_addr  <= 22'(pe.ctrl[ipt_pkg::CW_ADDR_HI:0]);
          mem_wdata <= pe.data[31:0];
          part_q    <= 1'b0;
          rd_data_q <= '0;
          p_state_q <= P_MEM;
        end
        P_MEM: if (mem_ack) begin
          if (part_q) begin
            rd_data_q[63:32] <= mem_rdata;
          end else begin
            rd_data_q[31:0] <= mem_wide ? mem_rdata : {16'h0000, mem_rdata[15:0]};
          end
          if (!mem_fin) begin
            part_q    <= 1'b1;
            mem_addr  <= mem_addr + ipt_pkg::ADDR_STEP;
            mem_wdata <= pe.data[63:32];
          end else begin
            mem_req   <= 1'b0;
            crc_q     <= ipt_pkg::CRC_INIT;
            k_q       <= '0;
            p_state_q <= mem_we ? P_IDLE : P_CRC;
          end
        end
        P_CRC: begin
          crc_q <= ipt_pkg::crc8(crc_q, crc_byte);
          k_q   <= k_q + 4'h1;
          if (tx_set) begin
            tx_buf_q[tf_sel_q] <= '{data: rd_data_q, crc: ipt_pkg::crc8(crc_q, crc_byte),
                                    n: pe_n, crc_en: pe_crc};
            p_state_q <= P_IDLE;
          end
        end
        default: p_state_q <= P_IDLE;
      endcase
    end
  end

  // Buffer occupancy, set wins over clear
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_full_q <= '0;
      tx_full_q <= '0;
      wr_sel_q  <= 1'b0;
      pr_sel_q  <= 1'b0;
      tf_sel_q  <= 1'b0;
      rd_sel_q  <= 1'b0;
    end else begin
      if (rx_clr) begin
        rx_full_q[pr_sel_q] <= 1'b0;
        pr_sel_q            <= ~pr_sel_q;
      end
      if (rx_set) begin
        rx_full_q[wr_sel_q] <= 1'b1;
        wr_sel_q            <= ~wr_sel_q;
      end
      if (tx_clr) begin
        tx_full_q[rd_sel_q] <= 1'b0;
        rd_sel_q            <= ~rd_sel_q;
      end
      if (tx_set) begin
        tx_full_q[tf_sel_q] <= 1'b1;
        tf_sel_q            <= ~tf_sel_q;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      drops_q <= '0;
    end else if (p_go && crc_bad && drops_q != 8'hff) begin
      drops_q <= drops_q + 8'h01;
    end
  end

  // APB register slave
  always_comb begin
    stat         = '0;
    stat.drops   = drops_q;
    stat.busy    = (p_state_q != P_IDLE);
    stat.tx_full = tx_full_q;
    stat.rx_full = rx_full_q;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tgt_q   <= ipt_pkg::ADDR_RST;
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= '0;
        if (8'(paddr) == ipt_pkg::REG_CFG) begin
          if (pwrite) begin
            tgt_q <= pwdata[6:0];
          end
          prdata <= {25'h0, tgt_q};
        end else if (8'(paddr) == ipt_pkg::REG_STAT) begin
          prdata <= stat;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  a_nack_rx_full: assert property (@(posedge clk) disable iff (!rst_b)
    addr_hit && !sr_next[0] && (&rx_full_q) |=> !ack_q ##1 (l_state_q != L_ACK) [*1])
    else $error("write address acked with both receive buffers full");
  a_nack_not_ready: assert property (@(posedge clk) disable iff (!rst_b)
    addr_hit && sr_next[0] && !tx_full_q[rd_sel_q] |=> !ack_q)
    else $error("read address acked with no transmit data");
  a_crc_drop: assert property (@(posedge clk) disable iff (!rst_b)
    p_go && crc_bad |=> !mem_req && p_state_q == P_IDLE)
    else $error("write with bad CRC reached memory");
  a_reserved_len: assert property (@(posedge clk) disable iff (!rst_b)
    p_go && pe_len == ipt_pkg::LENRSV |=> !mem_req && $changed(pr_sel_q))
    else $error("reserved length not discarded");
  a_second_half: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(part_q) |-> mem_addr == $past(mem_addr) + ipt_pkg::ADDR_STEP && mem_req)
    else $error("second half address not plus two");
  a_tx_full_wait: assert property (@(posedge clk) disable iff (!rst_b)
    p_go && pe_rd && (&tx_full_q) |=> p_state_q == P_IDLE && !mem_req)
    else $error("read processed with transmit buffers full");
  a_rx_capture: assert property (@(posedge clk) disable iff (!rst_b)
    rx_set && !rx_clr |=> $countones(rx_full_q) == $countones($past(rx_full_q)) + 1)
    else $error("captured request not held");
  a_tx_release: assert property (@(posedge clk) disable iff (!rst_b)
    tx_clr && !tx_set |=> $countones(tx_full_q) == $countones($past(tx_full_q)) - 1)
    else $error("transmit buffer not freed after readout");
  a_ack_drive: assert property (@(posedge clk) disable iff (!rst_b)
    l_state_q == L_ACKON && scl_fall && ack_q && !frame_end |=> !sda_oe_b)
    else $error("acknowledge not driven");
endmodule : ipt_engine

/* File: bench/ipt_mcu.sv */
`timescale 1ns/100ps
module ipt_mcu #(
  parameter int GAP = 4
) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_q
);
  logic [7:0] c_q;
  logic       ok_q;

  initial begin
    scl   = 1'b1;
    sda_q = 1'b1;
  end

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // SDA set in low phase, sampled in high phase
  task automatic bit_io(input logic b, output logic r);
    wt(2);
    sda_q <= b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    r = sda;
    wt(2);
    scl <= 1'b0;
  endtask : bit_io

  task automatic start;
    wt(2);
    sda_q <= 1'b1;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_q <= 1'b0;
    wt(4);
    scl <= 1'b0;
  endtask : start

  // SCL stands high after the frame
  task automatic stop;
    wt(2);
    sda_q <= 1'b0;
    wt(2);
    scl <= 1'b1;
    wt(4);
    sda_q <= 1'b1;
    wt(GAP);
  endtask : stop

  task automatic snd(input logic [7:0] b);
    logic r;
    wt(GAP);
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ok_q = ok_q & !r;
    c_q  = crc(c_q, b);
  endtask : snd

  // Write packet, or read request when the direction bit is set
  task automatic wr_pkt(input logic [6:0] dv, input logic [23:0] cw, input logic [63:0] d,
                        input int nb, input logic [7:0] cx);
    start();
    c_q  = 8'hff;
    ok_q = 1'b1;
    snd({dv, 1'b0});
    for (int i = 2; i >= 0 && ok_q; i--) begin
      snd(cw[8*i+:8]);
    end
    for (int i = 0; i < nb && ok_q && !cw[23]; i++) begin
      snd(d[8*i+:8]);
    end
    if (cw[22] && !cw[23] && ok_q) begin
      snd(c_q ^ cx);
    end
    stop();
  endtask : wr_pkt

  // Bare read phase; a refused address ends it
  task automatic rd_dat(input logic [6:0] dv, input int nb, output logic [71:0] q);
    logic r;
    q = '0;
    start();
    ok_q = 1'b1;
    snd({dv, 1'b1});
    for (int i = 0; i < nb && ok_q; i++) begin
      for (int j = 7; j >= 0; j--) begin
        bit_io(1'b1, r);
        q[8*i+j] = r;
      end
      bit_io(i == nb - 1, r);
    end
    stop();
  endtask : rd_dat
endmodule : ipt_mcu

/* File: bench/testbench.sv */
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic        dir;
    logic        crc;
    logic [1:0]  len;
    logic [19:0] adr;
    logic [63:0] dat;
  } ipt_row_type;

  logic        clk;
  logic        rst_b;
  logic        scl;
  logic        sda_q;
  wire         sda;
  logic        sda_o;
  logic        sda_oe_b;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        mem_req;
  logic        mem_we;
  logic        mem_wide;
  logic [21:0] mem_addr;
  logic [31:0] mem_wdata;
  logic        mem_ack;
  logic [31:0] mem_rdata;
  logic        hold;
  logic [55:0] log_q[$];
  int          error_cnt;
  int          cmp_count;
  ipt_row_type rows[6];

  assign sda = sda_q & (sda_oe_b | sda_o);

  ipt_engine u_ipt_engine (
    .clk       (clk),
    .rst_b     (rst_b),
    .scl_i     (scl),
    .sda_i     (sda),
    .sda_o     (sda_o),
    .sda_oe_b  (sda_oe_b),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_wide  (mem_wide),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  ipt_mcu u_ipt_mcu (
    .clk   (clk),
    .sda   (sda),
    .scl   (scl),
    .sda_q (sda_q)
  );

  always #12.5 clk = ~clk;

  function automatic logic [31:0] mv(input logic [21:0] a);
    return {~a[15:0], a[15:0]};
  endfunction : mv

  // Memory stub, stalls while hold is set
  always @(posedge clk) begin
    mem_ack   <= mem_req && !mem_ack && !hold;
    mem_rdata <= mv(mem_addr);
    if (mem_req && mem_ack) begin
      log_q.push_back({mem_we, mem_wide, mem_addr, mem_wdata});
    end
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n == 50) error_cnt++;
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wait_log(input int na);
    int n;
    n = 0;
    while (log_q.size() < na + (na == 0) && n < 300) begin
      @(posedge clk);
      n++;
    end
  endtask : wait_log

  task automatic rd_try(input int nb, output logic [71:0] q);
    int n;
    n = 0;
    do begin
      u_ipt_mcu.rd_dat(7'h01, nb, q);
      n++;
    end while (!u_ipt_mcu.ok_q && n < 20);
    chk(u_ipt_mcu.ok_q, 1'b1);
  endtask : rd_try

  task automatic chk_acc(input ipt_row_type r);
    logic [55:0] e;
    for (int k = 0; k < (r.len == 2'h2 ? 2 : 1); k++) begin
      e = log_q[k];
      chk(e[55:32], {!r.dir, r.len != 2'h0, 22'(r.adr) + 22'(2 * k)});
      if (!r.dir) begin
        chk(e[31:0] & (r.len == 2'h0 ? 32'hffff : 32'hffffffff), r.dat[32*k+:32]);
      end
    end
  endtask : chk_acc

  initial begin
    #1500000;
    error_cnt++;
    wrap_up();
  end

  initial begin
    ipt_row_type r;
    logic [23:0] cw;
    logic [63:0] ex;
    logic [63:0] m;
    logic [71:0] q;
    logic [31:0] d;
    logic [7:0]  c;
    logic [7:0]  cq;
    logic        e;
    int          nb;
    clk       = 1'b0;
    rst_b     = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = '0;
    pwdata    = '0;
    mem_ack   = 1'b0;
    mem_rdata = '0;
    hold      = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    rows = '{
      '{1'b0, 1'b0, 2'h0, 20'h35080, 64'h0000_0000_0000_beef},
      '{1'b0, 1'b1, 2'h1, 20'h00080, 64'h0000_0000_1234_abcd},
      '{1'b0, 1'b1, 2'h2, 20'h0f0fe, 64'h89ab_cdef_0123_4567},
      '{1'b1, 1'b1, 2'h0, 20'h12344, 64'h0},
      '{1'b1, 1'b0, 2'h1, 20'h00080, 64'h0},
      '{1'b1, 1'b1, 2'h2, 20'habcde, 64'h0}
    };
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk(sda_oe_b, 1'b1);
    apb(1'b0, 8'h00, '0, d, e);
    chk(d[6:0], 7'h01);
    apb(1'b0, 8'h04, '0, d, e);
    chk(d, 32'h0);
    apb(1'b0, 8'h08, '0, d, e);
    chk({e, d}, 33'h1_0000_0000);
    foreach (rows[i]) begin
      r  = rows[i];
      cw = {r.dir, r.crc, r.len, r.adr};
      nb = 2 << r.len;
      log_q.delete();
      u_ipt_mcu.wr_pkt(7'h01, cw, r.dat, nb, 8'h00);
      if (r.dir) begin
        cq = u_ipt_mcu.c_q;
        rd_try(nb + r.crc, q);
        ex = {mv(22'(r.adr) + 22'h2), mv(22'(r.adr))};
        m  = (64'h1 << (8 * nb)) - 64'h1;
        chk(q[63:0] & m, ex & m);
        c = u_ipt_mcu.crc(cq, 8'h03);
        for (int j = 0; j < nb; j++) c = u_ipt_mcu.crc(c, ex[8*j+:8]);
        if (r.crc) chk(q[8*nb+:8], c);
      end
      wait_log(r.len == 2'h2 ? 2 : 1);
      chk(log_q.size(), r.len == 2'h2 ? 2 : 1);
      chk_acc(r);
    end
    log_q.delete();
    u_ipt_mcu.wr_pkt(7'h01, 24'h510080, 64'h55aa, 4, 8'h01);
    u_ipt_mcu.wr_pkt(7'h01, 24'h300080, 64'h1111, 4, 8'h00);
    u_ipt_mcu.wr_pkt(7'h01, 24'h100080, 64'h2222, 2, 8'h00);
    wait_log(0);
    chk(log_q.size(), 0);
    apb(1'b0, 8'h04, '0, d, e);
    chk(d[15:8], 8'h01);
    hold <= 1'b1;
    u_ipt_mcu.wr_pkt(7'h01, 24'h100100, 64'ha1, 4, 8'h00);
    u_ipt_mcu.wr_pkt(7'h01, 24'h000200, 64'hb2, 2, 8'h00);
    chk(u_ipt_mcu.ok_q, 1'b1);
    u_ipt_mcu.wr_pkt(7'h01, 24'h000300, 64'hc3, 2, 8'h00);
    chk(u_ipt_mcu.ok_q, 1'b0);
    hold <= 1'b0;
    wait_log(2);
    chk(log_q.size(), 2);
    chk({log_q[0][53:32], log_q[1][53:32]}, {22'h100, 22'h200});
    chk({log_q[0][31:0], log_q[1][15:0]}, {32'ha1, 16'hb2});
    u_ipt_mcu.wr_pkt(7'h01, 24'h900400, '0, 0, 8'h00);
    ex = 64'(mv(22'h00400));
    rd_try(1, q);
    chk(q[7:0], ex[7:0]);
    rd_try(4, q);
    chk(q[31:0], ex[31:0]);
    u_ipt_mcu.rd_dat(7'h01, 1, q);
    chk(u_ipt_mcu.ok_q, 1'b0);
    u_ipt_mcu.wr_pkt(7'h01, 24'hb00700, '0, 0, 8'h00);
    u_ipt_mcu.rd_dat(7'h01, 1, q);
    chk(u_ipt_mcu.ok_q, 1'b0);
    for (int i = 0; i < 3; i++) begin
      u_ipt_mcu.wr_pkt(7'h01, 24'h900600 + 24'(i * 16), '0, 0, 8'h00);
    end
    apb(1'b0, 8'h04, '0, d, e);
    chk(d[3:2], 2'h3);
    for (int i = 0; i < 3; i++) begin
      rd_try(4, q);
      ex = 64'(mv(22'h00600 + 22'(i * 16)));
      chk(q[31:0], ex[31:0]);
    end
    apb(1'b1, 8'h00, 32'h22, d, e);
    log_q.delete();
    u_ipt_mcu.wr_pkt(7'h01, 24'h000500, 64'h1, 2, 8'h00);
    chk(u_ipt_mcu.ok_q, 1'b0);
    u_ipt_mcu.wr_pkt(7'h22, 24'h000500, 64'h1, 2, 8'h00);
    wait_log(1);
    chk(log_q.size(), 1);
    wrap_up();
  end
endmodule : testbench
